// ---- pkg/hbic_pkg.sv ----
// Constants, coefficient tables and carrier table of the halfband interpolation chain.
package hbic_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    // Control field positions.
    localparam int RATE_POS = 0;
    localparam int ZS_POS   = 2;
    localparam int REAL_POS = 3;
    localparam int MOD_POS  = 4;
    localparam int SIGN_POS = 6;
    localparam int CTRL_W   = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
    // Status field positions.
    localparam int CNT_POS  = 0;
    localparam int BUSY_POS = 16;
    // Modulation modes.
    localparam logic [1:0] MOD_NONE = 2'h0;
    localparam logic [1:0] MOD_FS2  = 2'h1;
    localparam logic [1:0] MOD_FS4  = 2'h2;
    localparam logic [1:0] MOD_FS8  = 2'h3;
    // Carrier amplitudes in Q1.14.
    localparam logic signed [15:0] CS_UNITY = 16'sh4000;
    localparam logic signed [15:0] CS_RT2   = 16'sh2d41;
    localparam int CS_SHIFT = 14;

    // Number of nonzero side taps per half of each stage.
    function automatic int side_taps(input int stg);
        case (stg)
            1:       return 11;
            2:       return 5;
            default: return 3;
        endcase
    endfunction

    // Centre tap of each stage as a power of two.
    function automatic int centre_shift(input int stg);
        case (stg)
            1:       return 14;
            2:       return 13;
            default: return 9;
        endcase
    endfunction

    // Nonzero side taps, outer to inner.
    function automatic logic signed [15:0] coef(input int stg, input int k);
        logic signed [15:0] c1 [11];
        logic signed [15:0] c2 [5];
        logic signed [15:0] c3 [3];
        c1 = '{16'sh0008, -16'sh001d, 16'sh0043, -16'sh0086, 16'sh00f4, -16'sh019e,
               16'sh02a1, -16'sh0437, 16'sh06ec, -16'sh0cd0, 16'sh287c};
        c2 = '{16'sh0013, -16'sh0078, 16'sh01b6, -16'sh0508, 16'sh13b7};
        c3 = '{16'sh0007, -16'sh0035, 16'sh012e};
        case (stg)
            1:       return c1[k];
            2:       return c2[k];
            default: return c3[k];
        endcase
    endfunction

    // Cosine of phase p times pi/4, in Q1.14.
    function automatic logic signed [15:0] carrier(input logic [2:0] p);
        case (p)
            3'h0:    return CS_UNITY;
            3'h1:    return CS_RT2;
            3'h2:    return 16'sh0000;
            3'h3:    return -CS_RT2;
            3'h4:    return -CS_UNITY;
            3'h5:    return -CS_RT2;
            3'h6:    return 16'sh0000;
            default: return CS_RT2;
        endcase
    endfunction
endpackage

// ---- pkg/hbic_stream_if.sv ----
// Sample stream between the chain's stages.
interface hbic_stream_if #(parameter int W = 14);
    logic                valid;
    logic signed [W-1:0] i_s;
    logic signed [W-1:0] q_s;
    modport source (output valid, output i_s, output q_s);
    modport sink   (input valid, input i_s, input q_s);
endinterface

// ---- logic/hbic_stage.sv ----
// One polyphase halfband interpolate-by-two stage for I and Q.
module hbic_stage #(
    parameter int STG = 1,
    parameter int W   = 14
) (
    input  wire logic       clk_sys,  // System clock.
    input  wire logic       reset,    // Synchronous reset, active high.
    input  wire logic       en,       // Stage is part of the active chain.
    input  wire logic [3:0] gap,      // Cycles between the two output phases.
    hbic_stream_if.sink     up,       // Input samples.
    hbic_stream_if.source   dn        // Output samples at twice the rate.
);
    localparam int M  = hbic_pkg::side_taps(STG);
    localparam int SH = hbic_pkg::centre_shift(STG);
    localparam int AW = W + 21;

    logic signed [W-1:0]  di_ff [2*M];
    logic signed [W-1:0]  dq_ff [2*M];
    logic signed [W-1:0]  nxt_di [2*M];
    logic signed [W-1:0]  nxt_dq [2*M];
    logic                 oddp_ff, nxt_oddp;
    logic [3:0]           cnt_ff, nxt_cnt;
    logic                 v_ff, nxt_v;
    logic signed [W-1:0]  oi_ff, oq_ff, nxt_oi, nxt_oq;
    logic signed [AW-1:0] acc_i, acc_q;

    // Folded symmetric sum; the zero alternate taps are never stored or multiplied.
    function automatic logic signed [AW-1:0] fold(input logic signed [W-1:0] d [2*M]);
        logic signed [AW-1:0] a;
        a = '0;
        for (int k = 0; k < M; k++) begin
            a = a + AW'(hbic_pkg::coef(STG, k)) * (AW'(d[k]) + AW'(d[2*M-1-k]));
        end
        return a;
    endfunction

    // Sum of all side taps, centre tap excluded; equals the centre tap for a unity-gain halfband.
    function automatic int tap_total();
        int s;
        s = 0;
        for (int k = 0; k < M; k++) begin
            s = s + 2 * int'(hbic_pkg::coef(STG, k));
        end
        return s;
    endfunction

    assign acc_i = fold(di_ff);
    assign acc_q = fold(dq_ff);

    // Shift in a sample, emit the folded phase, then the centre tap gap cycles later.
    always_comb begin
        nxt_di   = di_ff;
        nxt_dq   = dq_ff;
        nxt_oddp = 1'b0;
        nxt_cnt  = cnt_ff;
        nxt_v    = 1'b0;
        nxt_oi   = oi_ff;
        nxt_oq   = oq_ff;
        if (up.valid && en) begin
            for (int k = 2*M-1; k > 0; k--) begin
                nxt_di[k] = di_ff[k-1];
                nxt_dq[k] = dq_ff[k-1];
            end
            nxt_di[0] = up.i_s;
            nxt_dq[0] = up.q_s;
            nxt_oddp  = 1'b1;
        end
        if (oddp_ff) begin
            nxt_v   = 1'b1;
            nxt_oi  = W'(acc_i >>> SH);
            nxt_oq  = W'(acc_q >>> SH);
            nxt_cnt = gap;
        end else if (cnt_ff != 4'h0) begin
            nxt_cnt = cnt_ff - 4'h1;
            if (cnt_ff == 4'h1) begin
                nxt_v  = 1'b1;
                nxt_oi = di_ff[M-1];
                nxt_oq = dq_ff[M-1];
            end
        end
    end

    // State registers.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int k = 0; k < 2*M; k++) begin
                di_ff[k] <= '0;
                dq_ff[k] <= '0;
            end
            oddp_ff <= 1'b0;
            cnt_ff  <= 4'h0;
            v_ff    <= 1'b0;
            oi_ff   <= '0;
            oq_ff   <= '0;
        end else begin
            di_ff   <= nxt_di;
            dq_ff   <= nxt_dq;
            oddp_ff <= nxt_oddp;
            cnt_ff  <= nxt_cnt;
            v_ff    <= nxt_v;
            oi_ff   <= nxt_oi;
            oq_ff   <= nxt_oq;
        end
    end

    assign dn.valid = v_ff;
    assign dn.i_s   = oi_ff;
    assign dn.q_s   = oq_ff;

    property p_coef_unity;
        @(posedge clk_sys) disable iff (reset)
        1'b1 |-> (tap_total() == (1 << SH));
    endproperty
    a_coef_unity: assert property (p_coef_unity)
        else $error("Halfband taps do not sum to the centre tap.");

    property p_pair;
        @(posedge clk_sys) disable iff (reset)
        (up.valid && en && gap == 4'h1)
            |-> ##2 dn.valid ##1 dn.valid ##1 (dn.valid == $past(up.valid && en, 2));
    endproperty
    a_pair: assert property (p_pair)
        else $error("Stage did not emit two samples per input.");
endmodule // hbic_stage

// ---- logic/hbic_interp.sv ----
// Halfband interpolation chain with zero stuffing, carrier mixer and APB registers.
// What this block does
// - Stage one is a 43-tap symmetric halfband with centre 16384 and the listed odd taps.
// - Stage two is a 19-tap symmetric halfband with centre 8192 and the listed odd taps.
// - Stage three is an 11-tap symmetric halfband with centre 512 and the listed odd taps.
// - The chain runs at an integer multiple of the input rate and cuts just below half of it.
// - Each stage has constant group delay, so input-to-output latency is a fixed count.
// - Complex modulation multiplies I and Q by cos+j*sin, or by cos-j*sin while the sign bit is 0, and outputs both products.
// - A two-bit field selects 1x, 2x, 4x or 8x interpolation.
// - A one-bit field, when 1, inserts a zero after every chain sample.
// - A mixer field picks complex mixing at 0 and real mixing at 1.
module hbic_interp #(
    parameter int DW = 12
) (
    input  wire logic                 clk_sys,    // System clock, 100 MHz.
    input  wire logic                 reset,      // Synchronous reset, active high.
    input  wire logic                 psel,       // APB select.
    input  wire logic                 penable,    // APB access phase.
    input  wire logic                 pwrite,     // APB write.
    input  wire logic [11:0]          paddr,      // APB byte address.
    input  wire logic [31:0]          pwdata,     // APB write data.
    output logic      [31:0]          prdata,     // APB read data.
    output logic                      pready,     // APB ready.
    output logic                      pslverr,    // APB error on unmapped address.
    input  wire logic                 in_valid,   // Input sample offered.
    input  wire logic signed [DW-1:0] in_i,       // Input I sample.
    input  wire logic signed [DW-1:0] in_q,       // Input Q sample.
    output logic                      in_ready,   // Input sample taken this cycle.
    output logic                      out_valid,  // Output sample strobe.
    output logic signed [DW+1:0]      out_i,      // Output I sample.
    output logic signed [DW+1:0]      out_q       // Output Q sample.
);
    localparam int OW = DW + 2;
    localparam int PW = OW + 16;

    logic [hbic_pkg::CTRL_W-1:0] ctrl_ff, nxt_ctrl;
    logic [3:0]           cnt_ff, nxt_cnt;
    logic                 rdy_ff, nxt_rdy;
    logic                 cap_v_ff, nxt_cap_v;
    logic signed [OW-1:0] cap_i_ff, cap_q_ff, nxt_cap_i, nxt_cap_q;
    logic [15:0]          scount_ff, nxt_scount;
    logic                 zp_ff, nxt_zp;
    logic [2:0]           ph_ff, nxt_ph;
    logic                 ov_ff, nxt_ov;
    logic signed [OW-1:0] oi_ff, oq_ff, nxt_oi, nxt_oq;
    logic [31:0]          prdata_ff, nxt_prdata;
    logic                 pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic [1:0]           rate, mode;
    logic                 zs, real_mix, sgn, take, sel_v, mv;
    logic [4:0]           per;
    logic signed [OW-1:0] sel_i, sel_q, mi, mq;
    logic signed [15:0]   cs, sn;
    logic signed [PW-1:0] pii, pqs, pis, pqc;

    assign rate     = ctrl_ff[hbic_pkg::RATE_POS +: 2];
    assign zs       = ctrl_ff[hbic_pkg::ZS_POS];
    assign real_mix = ctrl_ff[hbic_pkg::REAL_POS];
    assign mode     = ctrl_ff[hbic_pkg::MOD_POS +: 2];
    assign sgn      = ctrl_ff[hbic_pkg::SIGN_POS];
    // Output slots per input sample; zero stuffing doubles it.
    assign per      = 5'h01 << (5'(rate) + 5'(zs));
    assign take     = in_valid && rdy_ff;

    // Chain of stages; inactive ones are gated off so their history stays frozen.
    hbic_stream_if #(.W(OW)) st [4] ();
    assign st[0].valid = cap_v_ff;
    assign st[0].i_s   = cap_i_ff;
    assign st[0].q_s   = cap_q_ff;
    for (genvar j = 1; j <= 3; j++) begin : g_stage
        hbic_stage #(.STG(j), .W(OW)) u_stage (
            .clk_sys (clk_sys),
            .reset   (reset),
            .en      (rate >= 2'(j)),
            .gap     (4'(per >> j)),
            .up      (st[j-1]),
            .dn      (st[j])
        );
    end

    // Pick the chain tap for the selected rate.
    always_comb begin
        case (rate)
            2'h0:    begin sel_v = st[0].valid; sel_i = st[0].i_s; sel_q = st[0].q_s; end
            2'h1:    begin sel_v = st[1].valid; sel_i = st[1].i_s; sel_q = st[1].q_s; end
            2'h2:    begin sel_v = st[2].valid; sel_i = st[2].i_s; sel_q = st[2].q_s; end
            default: begin sel_v = st[3].valid; sel_i = st[3].i_s; sel_q = st[3].q_s; end
        endcase
    end

    // Mixer operands; the zero slot lands one cycle after each chain sample.
    assign mv  = sel_v || zp_ff;
    assign mi  = zp_ff ? '0 : sel_i;
    assign mq  = zp_ff ? '0 : sel_q;
    assign cs  = hbic_pkg::carrier(ph_ff);
    assign sn  = sgn ? hbic_pkg::carrier(ph_ff + 3'h6) : -hbic_pkg::carrier(ph_ff + 3'h6);
    assign pii = PW'(mi) * PW'(cs);
    assign pqs = PW'(mq) * PW'(sn);
    assign pis = PW'(mi) * PW'(sn);
    assign pqc = PW'(mq) * PW'(cs);

    // Input pacing, zero stuffing and mixing.
    always_comb begin
        nxt_cnt    = (cnt_ff != 4'h0) ? cnt_ff - 4'h1 : cnt_ff;
        nxt_cap_v  = take;
        nxt_cap_i  = take ? OW'(in_i) : cap_i_ff;
        nxt_cap_q  = take ? OW'(in_q) : cap_q_ff;
        nxt_scount = take ? scount_ff + 16'h0001 : scount_ff;
        if (take) begin
            nxt_cnt = 4'(per - 5'h01);
        end
        nxt_rdy = (nxt_cnt == 4'h0);
        nxt_zp  = sel_v && zs;
        nxt_ov  = mv;
        nxt_oi  = oi_ff;
        nxt_oq  = oq_ff;
        nxt_ph  = ph_ff;
        if (mv) begin
            case (mode)
                hbic_pkg::MOD_FS2: nxt_ph = ph_ff + 3'h4;
                hbic_pkg::MOD_FS4: nxt_ph = ph_ff + 3'h2;
                hbic_pkg::MOD_FS8: nxt_ph = ph_ff + 3'h1;
                default:           nxt_ph = ph_ff;
            endcase
            if (mode == hbic_pkg::MOD_NONE) begin
                nxt_oi = mi;
                nxt_oq = mq;
            end else if (real_mix) begin
                nxt_oi = OW'(pii >>> hbic_pkg::CS_SHIFT);
                nxt_oq = OW'(pqc >>> hbic_pkg::CS_SHIFT);
            end else begin
                nxt_oi = OW'((pii - pqs) >>> hbic_pkg::CS_SHIFT);
                nxt_oq = OW'((pis + pqc) >>> hbic_pkg::CS_SHIFT);
            end
        end
    end

    // APB slave: one wait-free access phase, error on unmapped addresses.
    always_comb begin
        nxt_ctrl    = ctrl_ff;
        nxt_pready  = psel && !penable;
        nxt_pslverr = 1'b0;
        nxt_prdata  = prdata_ff;
        if (psel && !penable) begin
            case (paddr)
                hbic_pkg::CTRL_OFS:   nxt_prdata = 32'(ctrl_ff);
                hbic_pkg::STATUS_OFS: begin
                    nxt_prdata = 32'h0;
                    nxt_prdata[hbic_pkg::CNT_POS +: 16] = scount_ff;
                    nxt_prdata[hbic_pkg::BUSY_POS]     = !rdy_ff;
                end
                default: begin
                    nxt_prdata  = 32'h0;
                    nxt_pslverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && pready_ff && pwrite && paddr == hbic_pkg::CTRL_OFS) begin
            nxt_ctrl = pwdata[hbic_pkg::CTRL_W-1:0];
        end
    end

    // All state registers.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_ff    <= hbic_pkg::CTRL_RST;
            cnt_ff     <= 4'h0;
            rdy_ff     <= 1'b0;
            cap_v_ff   <= 1'b0;
            cap_i_ff   <= '0;
            cap_q_ff   <= '0;
            scount_ff  <= 16'h0000;
            zp_ff      <= 1'b0;
            ph_ff      <= 3'h0;
            ov_ff      <= 1'b0;
            oi_ff      <= '0;
            oq_ff      <= '0;
            prdata_ff  <= 32'h0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            ctrl_ff    <= nxt_ctrl;
            cnt_ff     <= nxt_cnt;
            rdy_ff     <= nxt_rdy;
            cap_v_ff   <= nxt_cap_v;
            cap_i_ff   <= nxt_cap_i;
            cap_q_ff   <= nxt_cap_q;
            scount_ff  <= nxt_scount;
            zp_ff      <= nxt_zp;
            ph_ff      <= nxt_ph;
            ov_ff      <= nxt_ov;
            oi_ff      <= nxt_oi;
            oq_ff      <= nxt_oq;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign in_ready  = rdy_ff;
    assign out_valid = ov_ff;
    assign out_i     = oi_ff;
    assign out_q     = oq_ff;

    property p_in_spacing;
        @(posedge clk_sys) disable iff (reset)
        (take && rate == 2'h3 && !zs) |=> !rdy_ff [*7] ##1 rdy_ff;
    endproperty
    a_in_spacing: assert property (p_in_spacing)
        else $error("8x input spacing is not eight cycles.");

    property p_bypass;
        @(posedge clk_sys) disable iff (reset)
        (take && rate == 2'h0 && !zs && mode == hbic_pkg::MOD_NONE)
            |-> ##2 (ov_ff && oi_ff == OW'($past(in_i, 2)) && oq_ff == OW'($past(in_q, 2)));
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("1x path did not pass the sample through.");

    property p_latency_2x;
        @(posedge clk_sys) disable iff (reset)
        (take && rate == 2'h1 && !zs) |-> ##4 ov_ff;
    endproperty
    a_latency_2x: assert property (p_latency_2x)
        else $error("2x latency is not four cycles.");

    property p_zero_stuff;
        @(posedge clk_sys) disable iff (reset)
        zp_ff |=> (ov_ff && oi_ff == '0 && oq_ff == '0);
    endproperty
    a_zero_stuff: assert property (p_zero_stuff)
        else $error("Stuffed slot did not carry zero.");

    property p_mix_cplx;
        @(posedge clk_sys) disable iff (reset)
        (mv && mode == hbic_pkg::MOD_FS4 && !real_mix && sgn && ph_ff == 3'h2)
            |=> (oi_ff == OW'(-$past(mq)) && oq_ff == $past(mi));
    endproperty
    a_mix_cplx: assert property (p_mix_cplx)
        else $error("Complex mix at quarter turn is wrong.");

    property p_mix_real;
        @(posedge clk_sys) disable iff (reset)
        (mv && mode != hbic_pkg::MOD_NONE && real_mix && ph_ff == 3'h0)
            |=> (oi_ff == $past(mi) && oq_ff == $past(mq));
    endproperty
    a_mix_real: assert property (p_mix_real)
        else $error("Real mix at zero phase is wrong.");
endmodule // hbic_interp

// ---- verif/hbic_src_model.sv ----
// Baseband sample source that feeds the chain's input handshake.
module hbic_src_model #(
    parameter int DW = 12
) (
    input  wire logic            clk_sys,   // System clock.
    input  wire logic            reset,     // Synchronous reset, active high.
    input  wire logic            in_ready,  // Chain takes the offered sample.
    output logic                 in_valid,  // Sample offered.
    output logic signed [DW-1:0] in_i,      // I sample.
    output logic signed [DW-1:0] in_q       // Q sample.
);
    timeunit 1ns;
    timeprecision 100ps;

    logic signed [DW-1:0] qi[$];
    logic signed [DW-1:0] qq[$];
    int                   gap = 0;   // Idle cycles after each take, for a slow source.
    int                   idle = 0;

    // Lines start low so nothing is offered before reset ends.
    initial begin
        in_valid = 1'b0;
        in_i = '0;
        in_q = '0;
    end

    // Queue one I and Q pair for sending.
    task automatic push(input logic signed [DW-1:0] i, input logic signed [DW-1:0] q);
        qi.push_back(i);
        qq.push_back(q);
    endtask

    // An offer is held until taken; idle data toggles so stale values never pass for fresh.
    always @(posedge clk_sys) begin
        if (in_valid && in_ready) begin
            void'(qi.pop_front());
            void'(qq.pop_front());
            idle = gap;
        end else if (idle > 0) begin
            idle--;
        end
        if (!reset && idle == 0 && qi.size() > 0) begin
            in_valid <= 1'b1;
            in_i <= qi[0];
            in_q <= qq[0];
        end else begin
            in_valid <= 1'b0;
            in_i <= ~in_i;
            in_q <= ~in_q;
        end
    end
endmodule // hbic_src_model

// ---- verif/tb_top.sv ----
// Self-checking bench for the halfband interpolation chain.
`define CHK(nm, e, g) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("mismatch %s exp %0d got %0d", nm, e, g); \
    end \
end

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int DW = 12;
    localparam int OW = DW + 2;
    localparam int X  = 1000;
    localparam int Y  = 300;
    localparam int SH = hbic_pkg::CS_SHIFT;

    logic                 clk_sys = 1'b0;
    logic                 reset   = 1'b1;
    logic                 psel    = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite  = 1'b0;
    logic [11:0]          paddr   = 12'h000;
    logic [31:0]          pwdata  = 32'h0;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 in_valid;
    logic                 in_ready;
    logic                 out_valid;
    logic signed [DW-1:0] in_i;
    logic signed [DW-1:0] in_q;
    logic signed [OW-1:0] out_i;
    logic signed [OW-1:0] out_q;
    logic signed [OW-1:0] oi_q[$];
    logic signed [OW-1:0] oq_q[$];
    int                   take_t[$];
    int                   out_t[$];
    int                   miscompares = 0;
    int                   n_tests = 0;
    int                   cyc = 0;
    int                   pushed = 0;
    logic [31:0]          rd;
    logic                 er;

    hbic_interp #(.DW(DW)) DUT (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .in_valid  (in_valid),
        .in_i      (in_i),
        .in_q      (in_q),
        .in_ready  (in_ready),
        .out_valid (out_valid),
        .out_i     (out_i),
        .out_q     (out_q)
    );

    hbic_src_model #(.DW(DW)) SRC (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .in_ready (in_ready),
        .in_valid (in_valid),
        .in_i     (in_i),
        .in_q     (in_q)
    );

    // Free-running 100 MHz clock.
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // Log takes and outputs by cycle; values read here predate this edge's updates.
    always @(posedge clk_sys) begin
        cyc++;
        if (in_valid === 1'b1 && in_ready === 1'b1) begin
            take_t.push_back(cyc);
        end
        if (out_valid === 1'b1) begin
            oi_q.push_back(out_i);
            oq_q.push_back(out_q);
            out_t.push_back(cyc);
        end
    end

    // A hang anywhere ends the run as a failure.
    initial begin
        repeat (40000) @(posedge clk_sys);
        miscompares++;
        final_report();
    end

    task automatic final_report();
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One APB transfer; the request is held until pready is seen at an edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset();
        reset <= 1'b1;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        for (int w = 0; w < 10 && in_ready !== 1'b1; w++) begin
            @(posedge clk_sys);
        end
    endtask

    // Configure, stream n samples and wait for the whole burst; checks count and latency.
    task automatic run(input logic [1:0] rate, input logic zs, input logic [1:0] md,
                       input logic sg, input logic rl, input int n, input int a,
                       input int b, input bit alt);
        int m;
        m = 1 << (int'(rate) + int'(zs));
        apb(1'b1, hbic_pkg::CTRL_OFS, {25'h0, sg, md, rl, zs, rate});
        oi_q.delete();
        oq_q.delete();
        take_t.delete();
        out_t.delete();
        for (int k = 0; k < n; k++) begin
            SRC.push(DW'(alt && k % 2 ? -a : a), DW'(alt && k % 2 ? -b : b));
        end
        pushed += n;
        for (int w = 0; w < 3000 && oi_q.size() < n * m; w++) begin
            @(posedge clk_sys);
        end
        repeat (10) @(posedge clk_sys);
        `CHK("count", n * m, oi_q.size())
        for (int k = 0; k < n && k < take_t.size() && k * m < out_t.size(); k++) begin
            `CHK("latency", 2 + 2 * int'(rate), out_t[k * m] - take_t[k])
        end
    endtask

    // Reset values, read-back masking and an unmapped address.
    task automatic t_regs();
        apb(1'b0, hbic_pkg::CTRL_OFS, 32'h0);
        `CHK("ctrl_rst", 32'h0, rd)
        apb(1'b0, hbic_pkg::STATUS_OFS, 32'h0);
        `CHK("status_rst", 32'h0, rd)
        apb(1'b1, hbic_pkg::CTRL_OFS, 32'hffffffff);
        apb(1'b1, 12'h008, 32'h0);
        `CHK("bad_wr_err", 1'b1, er)
        apb(1'b0, 12'h008, 32'h0);
        `CHK("bad_rd_err", 1'b1, er)
        `CHK("bad_rd_data", 32'h0, rd)
        apb(1'b0, hbic_pkg::CTRL_OFS, 32'h0);
        `CHK("ctrl_rw", 32'h7f, rd)
    endtask

    // At 1x every sample passes untouched, full-scale values included.
    task automatic t_pass();
        run(2'h0, 1'b0, hbic_pkg::MOD_NONE, 1'b0, 1'b0, 6, 2047, -2047, 1'b1);
        for (int k = 0; k < oi_q.size(); k++) begin
            `CHK("pass_i", k % 2 ? -2047 : 2047, oi_q[k])
            `CHK("pass_q", k % 2 ? 2047 : -2047, oq_q[k])
        end
        apb(1'b0, hbic_pkg::STATUS_OFS, 32'h0);
        `CHK("status_cnt", pushed & 32'hffff, rd)
    endtask

    // Tap sums give exact unity gain at DC through one, two and three stages.
    task automatic t_dc();
        for (int r = 1; r < 4; r++) begin
            SRC.gap = (r == 2) ? 5 : 0;
            run(2'(r), 1'b0, hbic_pkg::MOD_NONE, 1'b0, 1'b0, 48, X, -Y, 1'b0);
            for (int k = oi_q.size() * 3 / 4; k < oi_q.size(); k++) begin
                `CHK("dc_i", X, oi_q[k])
                `CHK("dc_q", -Y, oq_q[k])
            end
        end
        SRC.gap = 0;
    endtask

    // An input at half its rate cancels in the folded phase; only the centre tap passes.
    task automatic t_alt();
        run(2'h1, 1'b0, hbic_pkg::MOD_NONE, 1'b0, 1'b0, 48, X, Y, 1'b1);
        for (int k = 72; k < oi_q.size(); k++) begin
            if (k % 2 == 0) begin
                `CHK("alt_fold", 0, oi_q[k])
            end else begin
                `CHK("alt_centre", (k / 2) % 2 ? -X : X, oi_q[k])
            end
        end
    endtask

    // Zero stuffing puts a zero after every chain sample.
    task automatic t_zs();
        run(2'h1, 1'b1, hbic_pkg::MOD_NONE, 1'b0, 1'b0, 48, X, Y, 1'b0);
        for (int k = 144; k < oi_q.size(); k++) begin
            `CHK("zs_i", k % 2 ? 0 : X, oi_q[k])
        end
    endtask

    function automatic int cs(input int p);
        int t[8];
        t = '{hbic_pkg::CS_UNITY, hbic_pkg::CS_RT2, 0, -hbic_pkg::CS_RT2,
              -hbic_pkg::CS_UNITY, -hbic_pkg::CS_RT2, 0, hbic_pkg::CS_RT2};
        return t[p & 7];
    endfunction

    // Every carrier mode after a fresh reset, so the carrier phase is known from zero.
    task automatic t_mix();
        logic [1:0] md[5] = '{hbic_pkg::MOD_FS8, hbic_pkg::MOD_FS4, hbic_pkg::MOD_FS4,
                              hbic_pkg::MOD_FS2, hbic_pkg::MOD_FS8};
        logic       sg[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        logic       rl[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        int         ph;
        int         st;
        int         c;
        int         s;
        do_reset();
        apb(1'b0, hbic_pkg::CTRL_OFS, 32'h0);
        `CHK("ctrl_rst2", 32'h0, rd)
        ph = 0;
        for (int j = 0; j < 5; j++) begin
            run(2'h0, 1'b0, md[j], sg[j], rl[j], 8, X, Y, 1'b0);
            st = md[j] == hbic_pkg::MOD_FS2 ? 4 : md[j] == hbic_pkg::MOD_FS4 ? 2 : 1;
            for (int k = 0; k < oi_q.size(); k++) begin
                c = cs(ph);
                s = sg[j] ? cs(ph + 6) : -cs(ph + 6);
                `CHK("mix_i", rl[j] ? (X * c) >>> SH : (X * c - Y * s) >>> SH, oi_q[k])
                `CHK("mix_q", rl[j] ? (Y * c) >>> SH : (X * s + Y * c) >>> SH, oq_q[k])
                ph = (ph + st) & 7;
            end
        end
    endtask

    // Main sequence.
    initial begin
        do_reset();
        t_regs();
        t_pass();
        t_dc();
        t_alt();
        t_zs();
        t_mix();
        final_report();
    end
endmodule // tb_top
